// *** raf_pkg.sv ***
// Constants, carriers and state layout of the RS485 unit address filter
package raf_pkg;

	// APB register map (byte addresses)
	localparam logic [7:0] RAF_CTRL_OFS     = 8'h00;
	localparam logic [7:0] RAF_ADDR_OFS     = 8'h04;
	localparam logic [7:0] RAF_PREFIX_OFS   = 8'h08;
	localparam logic [7:0] RAF_STATUS_OFS   = 8'h0c;

	// Control register fields
	localparam int RAF_CTRL_PFX_MODE   = 0;
	localparam int RAF_CTRL_STN_PERMIT = 1;
	localparam int RAF_CTRL_PAR_EN     = 2;
	localparam int RAF_CTRL_PAR_ODD    = 3;
	localparam int RAF_CTRL_ECHO_BLANK = 4;

	// Status register fields
	localparam int RAF_STAT_MULTIDROP  = 0;
	localparam int RAF_STAT_ECHO_BLANK = 1;
	localparam int RAF_STAT_BURST      = 2;
	localparam int RAF_STAT_ADDRESSED  = 3;
	localparam int RAF_STAT_TX_ALLOW   = 4;

	// Bus population limit kept by the host
	localparam int RAF_MAX_UNITS = 31;

	// ASCII characters
	localparam logic [7:0] RAF_CR    = 8'h0d;
	localparam logic [7:0] RAF_ACK   = 8'h41;
	localparam logic [7:0] RAF_NAK   = 8'h3f;
	localparam logic [7:0] RAF_BC_BURST = 8'h31;
	localparam logic [7:0] RAF_BC_BLANK = 8'h32;
	localparam logic [7:0] RAF_BC_CLEAR = 8'h58;
	localparam logic [7:0] RAF_CODE_BASE = 8'h41;

	// Local command spellings
	localparam logic [15:0] RAF_ENTER_MULTIDROP_MODE_CMD    = 16'h4734;
	localparam logic [15:0] RAF_ENTER_FULLDUPLEX_BUS_CMD    = 16'h4732;
	localparam logic [15:0] RAF_READ_UNIT_ADDRESS_CMD       = 16'h5241;
	localparam logic [15:0] RAF_SET_UNIT_ADDRESS_CMD        = 16'h4541;
	localparam logic [15:0] RAF_SAVE_SETTINGS_CMD           = 16'h5345;
	localparam logic [15:0] RAF_BLANK_ECHO_CMD              = 16'h4245;
	localparam logic [15:0] RAF_BURST_OUTPUT_CMD            = 16'h424e;
	localparam logic [15:0] RAF_SELECT_PREFIX_ADDRESSING_CMD = 16'h5541;
	localparam logic [15:0] RAF_SELECT_PARITY_ADDRESSING_CMD = 16'h5553;
	localparam logic [15:0] RAF_SET_UNIT_PREFIX_CMD         = 16'h5249;
	localparam logic [15:0] RAF_SET_BCAST_PREFIX_CMD        = 16'h4249;

	// Unit address codes for unit_number 1 to 16
	localparam logic [15:0][7:0] RAF_UNIT_CODES = {8'h55, 8'h53, 8'h50, 8'h4e, 8'h4d, 8'h4b, 8'h48, 8'h47,
		8'h44, 8'h42, 8'h41, 8'h39, 8'h36, 8'h35, 8'h33, 8'h30};

	// Prefix characters for code letters A (index 0) to U; zero marks an unused code
	localparam logic [20:0][7:0] RAF_PFX_CHARS = {8'h7e, 8'h7d, 8'h7c, 8'h7b, 8'h5d, 8'h5c, 8'h3e, 8'h00,
		8'h3c, 8'h3b, 8'h3a, 8'h2f, 8'h2a, 8'h29, 8'h28, 8'h27, 8'h26, 8'h25, 8'h24, 8'h23, 8'h22};

	// Reset values
	localparam logic [7:0] RAF_ADDR_RST     = 8'h30;
	localparam logic [7:0] RAF_UNIT_PFX_RST = 8'h24;
	localparam logic [7:0] RAF_BC_PFX_RST   = 8'h26;

	typedef enum logic [3:0] {
		RAF_IDLE  = 4'b0001,
		RAF_PFX_U = 4'b0010,
		RAF_PFX_B = 4'b0100,
		RAF_CMD   = 4'b1000
	} raf_fsm_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} raf_char_s;

	typedef struct packed {
		logic       valid;
		logic       nine;
		logic [8:0] data;
	} raf_bus_char_s;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} raf_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} raf_apb_rsp_s;

	typedef struct packed {
		raf_fsm_e     fsm;
		logic         multidrop;
		logic         echo_blank;
		logic         burst;
		logic         pfx_mode;
		logic         stn_permit;
		logic         par_en;
		logic         par_odd;
		logic [7:0]   unit_addr;
		logic [7:0]   unit_pfx;
		logic [7:0]   bc_pfx;
		logic         tx_allow;
		logic [2:0][7:0] cbuf;
		logic [1:0]   clen;
		logic         covf;
		logic [15:0]  rpl;
		logic [1:0]   rpl_v;
		raf_char_s    cmd;
		logic         cmd_src;
		logic         cmd_end;
		logic         cmd_local;
		logic         bc_valid;
		logic [7:0]   bc_code;
		logic [3:0]   combo;
		logic         save;
		logic         echo_en;
		logic         panel_lock;
		logic         stn_en;
		raf_apb_rsp_s rsp;
	} raf_state_s;

	localparam raf_state_s RAF_STATE_RST = '{fsm: RAF_IDLE, unit_addr: RAF_ADDR_RST, unit_pfx: RAF_UNIT_PFX_RST,
		bc_pfx: RAF_BC_PFX_RST, tx_allow: 1'b1, echo_en: 1'b1, stn_en: 1'b1, default: '0};

endpackage

// *** raf_unit_filter.sv ***
// RS485 multidrop address and broadcast filter with local mode commands
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module raf_unit_filter
(
	input  wire logic                   clk_in,
	input  wire logic                   nrst_in,
	input  wire logic                   ce_in,
	input  wire raf_pkg::raf_apb_req_s  apb_req_in,
	output raf_pkg::raf_apb_rsp_s       apb_rsp_out,
	input  wire raf_pkg::raf_char_s     p2p_rx_in,
	input  wire raf_pkg::raf_bus_char_s bus_rx_in,
	input  wire logic                   reply_ready_in,
	output logic                        reply_valid_out,
	output logic [7:0]                  reply_data_out,
	output raf_pkg::raf_char_s          cmd_out,
	output logic                        cmd_src_bus_out,
	output logic                        cmd_end_out,
	output logic                        cmd_local_out,
	output logic                        bcast_valid_out,
	output logic [7:0]                  bcast_code_out,
	output logic [3:0]                  bcast_combo_out,
	output logic                        save_pulse_out,
	output logic                        echo_enable_out,
	output logic                        panel_lock_out,
	output logic                        station_select_enable_out,
	output logic                        bus_tx_allow_out,
	output logic                        multidrop_out,
	output logic                        burst_out
);
	import raf_pkg::*;

	raf_state_s st_reg;
	raf_state_s st_next;

	function automatic logic even9(input logic [8:0] x);
		even9 = ~(^x);
	endfunction

	function automatic logic unit_code_ok(input logic [7:0] c);
		unit_code_ok = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			if (RAF_UNIT_CODES[i] == c)
				unit_code_ok = 1'b1;
		end
	endfunction

	function automatic logic [7:0] pfx_char(input logic [7:0] code);
		logic [7:0] idx;
		idx = code - RAF_CODE_BASE;
		pfx_char = (code >= RAF_CODE_BASE && idx < 8'd21) ? RAF_PFX_CHARS[idx[4:0]] : 8'h00;
	endfunction

	logic        apb_acc;
	logic        apb_done;
	logic        apb_hit;
	logic [31:0] apb_rd;
	logic        loc_hit;
	logic        loc_err;
	logic [7:0]  loc_rpl;
	logic        bc_hit;
	logic [7:0]  bc_ch;
	logic [7:0]  ch;
	logic        perr;
	logic [7:0]  pc;

	always_comb
	begin
		st_next = st_reg;
		apb_acc = apb_req_in.psel & apb_req_in.penable;
		apb_done = apb_acc & st_reg.rsp.pready;
		apb_hit = 1'b1;
		apb_rd = 32'h0;
		loc_hit = 1'b0;
		loc_err = 1'b0;
		loc_rpl = RAF_ACK;
		bc_hit = 1'b0;
		bc_ch = 8'h00;
		pc = 8'h00;
		ch = st_reg.par_en ? {1'b0, bus_rx_in.data[6:0]} : bus_rx_in.data[7:0];
		perr = st_reg.par_en & ((^bus_rx_in.data[7:0]) != st_reg.par_odd);
		st_next.cmd.valid = 1'b0;
		st_next.cmd_end = 1'b0;
		st_next.cmd_local = 1'b0;
		st_next.bc_valid = 1'b0;
		st_next.combo = 4'h0;
		st_next.save = 1'b0;
		st_next.rsp.pready = 1'b0;

		// Register decode
		if (apb_req_in.paddr == RAF_CTRL_OFS)
			apb_rd = {27'h0, st_reg.echo_blank, st_reg.par_odd, st_reg.par_en, st_reg.stn_permit, st_reg.pfx_mode};
		else if (apb_req_in.paddr == RAF_ADDR_OFS)
			apb_rd = {24'h0, st_reg.unit_addr};
		else if (apb_req_in.paddr == RAF_PREFIX_OFS)
			apb_rd = {16'h0, st_reg.bc_pfx, st_reg.unit_pfx};
		else if (apb_req_in.paddr == RAF_STATUS_OFS)
			apb_rd = {27'h0, st_reg.tx_allow, st_reg.fsm == RAF_CMD, st_reg.burst, st_reg.echo_blank,
				st_reg.multidrop};
		else
			apb_hit = 1'b0;

		// One wait state, then completion
		if (apb_acc & ~st_reg.rsp.pready)
		begin
			st_next.rsp.pready = 1'b1;
			st_next.rsp.prdata = apb_req_in.pwrite ? 32'h0 : apb_rd;
			st_next.rsp.pslverr = ~apb_hit;
		end
		if (apb_done & apb_req_in.pwrite & apb_hit)
		begin
			if (apb_req_in.paddr == RAF_CTRL_OFS)
			begin
				st_next.pfx_mode = apb_req_in.pwdata[RAF_CTRL_PFX_MODE];
				st_next.stn_permit = apb_req_in.pwdata[RAF_CTRL_STN_PERMIT];
				st_next.par_en = apb_req_in.pwdata[RAF_CTRL_PAR_EN];
				st_next.par_odd = apb_req_in.pwdata[RAF_CTRL_PAR_ODD];
				st_next.echo_blank = apb_req_in.pwdata[RAF_CTRL_ECHO_BLANK];
			end
			else if (apb_req_in.paddr == RAF_ADDR_OFS)
				st_next.unit_addr = apb_req_in.pwdata[7:0];
			else if (apb_req_in.paddr == RAF_PREFIX_OFS)
			begin
				st_next.unit_pfx = apb_req_in.pwdata[7:0];
				st_next.bc_pfx = apb_req_in.pwdata[15:8];
			end
		end

		// Reply drain
		if (st_reg.rpl_v[0] & reply_ready_in)
		begin
			st_next.rpl = {8'h00, st_reg.rpl[15:8]};
			st_next.rpl_v = {1'b0, st_reg.rpl_v[1]};
		end

		if (p2p_rx_in.valid)
		begin
			st_next.multidrop = 1'b0;
			st_next.fsm = RAF_IDLE;
			st_next.tx_allow = 1'b1;
			st_next.cmd.valid = 1'b1;
			st_next.cmd.data = p2p_rx_in.data;
			st_next.cmd_src = 1'b0;
			if (p2p_rx_in.data == RAF_CR)
			begin
				st_next.cmd_end = 1'b1;
				st_next.clen = 2'd0;
				st_next.covf = 1'b0;
				if (~st_reg.covf && st_reg.clen == 2'd2)
				begin
					loc_hit = 1'b1;
					case ({st_reg.cbuf[0], st_reg.cbuf[1]})
						RAF_ENTER_MULTIDROP_MODE_CMD:
						begin
							st_next.multidrop = 1'b1;
							st_next.echo_blank = 1'b1;
							st_next.tx_allow = 1'b0;
						end
						RAF_ENTER_FULLDUPLEX_BUS_CMD: loc_err = 1'b1;
						RAF_READ_UNIT_ADDRESS_CMD: loc_rpl = st_reg.unit_addr;
						RAF_SAVE_SETTINGS_CMD: st_next.save = 1'b1;
						RAF_BLANK_ECHO_CMD: st_next.echo_blank = 1'b1;
						RAF_BURST_OUTPUT_CMD: st_next.burst = 1'b1;
						RAF_SELECT_PREFIX_ADDRESSING_CMD: st_next.pfx_mode = 1'b1;
						RAF_SELECT_PARITY_ADDRESSING_CMD: st_next.pfx_mode = 1'b0;
						default: loc_hit = 1'b0;
					endcase
				end
				else if (~st_reg.covf && st_reg.clen == 2'd3)
				begin
					loc_hit = 1'b1;
					pc = pfx_char(st_reg.cbuf[2]);
					case ({st_reg.cbuf[0], st_reg.cbuf[1]})
						RAF_SET_UNIT_ADDRESS_CMD:
						begin
							if (unit_code_ok(st_reg.cbuf[2]))
								st_next.unit_addr = st_reg.cbuf[2];
							else
								loc_err = 1'b1;
						end
						RAF_SET_UNIT_PREFIX_CMD:
						begin
							if (pc != 8'h00)
								st_next.unit_pfx = pc;
							else
								loc_err = 1'b1;
						end
						RAF_SET_BCAST_PREFIX_CMD:
						begin
							if (pc != 8'h00)
								st_next.bc_pfx = pc;
							else
								loc_err = 1'b1;
						end
						default: loc_hit = 1'b0;
					endcase
				end
				st_next.cmd_local = loc_hit;
				if (loc_hit && st_next.rpl_v == 2'b00)
				begin
					st_next.rpl = {RAF_CR, loc_err ? RAF_NAK : loc_rpl};
					st_next.rpl_v = 2'b11;
				end
			end
			else if (st_reg.clen == 2'd3)
				st_next.covf = 1'b1;
			else
			begin
				st_next.cbuf[st_reg.clen] = p2p_rx_in.data;
				st_next.clen = st_reg.clen + 2'd1;
			end
		end
		else if (bus_rx_in.valid & st_reg.multidrop)
		begin
			if (~st_reg.pfx_mode & bus_rx_in.nine)
			begin
				st_next.fsm = RAF_IDLE;
				st_next.tx_allow = 1'b0;
				if (even9(bus_rx_in.data))
				begin
					if (bus_rx_in.data[7:0] == st_reg.unit_addr)
						st_next.fsm = RAF_CMD;
				end
				else
				begin
					bc_hit = 1'b1;
					bc_ch = bus_rx_in.data[7:0];
				end
			end
			else
			begin
				case (st_reg.fsm)
					RAF_IDLE:
					begin
						if (st_reg.pfx_mode && ch == st_reg.unit_pfx)
						begin
							st_next.fsm = RAF_PFX_U;
							st_next.tx_allow = 1'b0;
						end
						else if (st_reg.pfx_mode && ch == st_reg.bc_pfx)
						begin
							st_next.fsm = RAF_PFX_B;
							st_next.tx_allow = 1'b0;
						end
					end
					RAF_PFX_U:
						st_next.fsm = (ch == st_reg.unit_addr) ? RAF_CMD : RAF_IDLE;
					RAF_PFX_B:
					begin
						bc_hit = 1'b1;
						bc_ch = ch;
						st_next.fsm = RAF_IDLE;
					end
					RAF_CMD:
					begin
						st_next.cmd.valid = ~perr;
						st_next.cmd.data = ch;
						st_next.cmd_src = 1'b1;
						if (perr | (ch == RAF_CR))
						begin
							st_next.cmd_end = 1'b1;
							st_next.cmd_local = perr;
							st_next.tx_allow = ~perr;
							st_next.fsm = RAF_IDLE;
						end
					end
					default: st_next.fsm = RAF_IDLE;
				endcase
			end
		end

		if (bc_hit)
		begin
			st_next.bc_valid = 1'b1;
			st_next.bc_code = bc_ch;
			st_next.tx_allow = 1'b0;
			if (bc_ch == RAF_BC_BURST)
				st_next.combo = 4'h1;
			else if (bc_ch == RAF_BC_BLANK)
				st_next.combo = 4'h2;
			else if (bc_ch == RAF_BC_CLEAR)
				st_next.combo = 4'hf;
			if (st_next.combo[0])
				st_next.burst = 1'b1;
			if (st_next.combo[1])
				st_next.echo_blank = 1'b1;
		end

		if (~st_next.multidrop)
			st_next.tx_allow = 1'b1;
		st_next.echo_en = ~st_next.multidrop & ~st_next.echo_blank;
		st_next.panel_lock = st_next.multidrop;
		st_next.stn_en = ~st_next.multidrop | st_next.stn_permit;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			st_reg <= RAF_STATE_RST;
		else if (ce_in)
			st_reg <= st_next;
	end

	assign apb_rsp_out = st_reg.rsp;
	assign reply_valid_out = st_reg.rpl_v[0];
	assign reply_data_out = st_reg.rpl[7:0];
	assign cmd_out = st_reg.cmd;
	assign cmd_src_bus_out = st_reg.cmd_src;
	assign cmd_end_out = st_reg.cmd_end;
	assign cmd_local_out = st_reg.cmd_local;
	assign bcast_valid_out = st_reg.bc_valid;
	assign bcast_code_out = st_reg.bc_code;
	assign bcast_combo_out = st_reg.combo;
	assign save_pulse_out = st_reg.save;
	assign echo_enable_out = st_reg.echo_en;
	assign panel_lock_out = st_reg.panel_lock;
	assign station_select_enable_out = st_reg.stn_en;
	assign bus_tx_allow_out = st_reg.tx_allow;
	assign multidrop_out = st_reg.multidrop;
	assign burst_out = st_reg.burst;

	no_echo_bus_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		st_reg.multidrop |-> !echo_enable_out && !st_reg.echo_en)
		else $error("echo enabled in multidrop mode");

	panel_locked_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		multidrop_out |-> panel_lock_out && (station_select_enable_out == st_reg.stn_permit))
		else $error("front panel not locked in multidrop mode");

	single_cmd_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		ce_in && st_reg.fsm == RAF_CMD && bus_rx_in.valid && !bus_rx_in.nine && !p2p_rx_in.valid
		&& st_reg.multidrop && (bus_rx_in.data[7:0] == RAF_CR) && !st_reg.par_en |=> st_reg.fsm == RAF_IDLE && cmd_end_out)
		else $error("addressed window not closed after command end");

	bcast_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		bcast_valid_out |-> !bus_tx_allow_out && !cmd_out.valid)
		else $error("reply allowed after broadcast");

	discard_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		ce_in && st_reg.fsm == RAF_IDLE && bus_rx_in.valid && !p2p_rx_in.valid |=> !cmd_out.valid)
		else $error("unaddressed traffic forwarded");

	addr_open_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		ce_in && st_reg.multidrop && !st_reg.pfx_mode && bus_rx_in.valid && bus_rx_in.nine && !p2p_rx_in.valid
		&& even9(bus_rx_in.data) && bus_rx_in.data[7:0] == st_reg.unit_addr |=> st_reg.fsm == RAF_CMD)
		else $error("own address did not open command window");

	clear_combo_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		bcast_valid_out && bcast_code_out == RAF_BC_CLEAR |-> bcast_combo_out == 4'hf && burst_out && !echo_enable_out)
		else $error("clear broadcast missed a setting");

	p2p_exit_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		ce_in && p2p_rx_in.valid && p2p_rx_in.data != RAF_CR |=> !multidrop_out && bus_tx_allow_out)
		else $error("multidrop mode kept after point-to-point character");

	apb_wait_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		ce_in && apb_req_in.psel && apb_req_in.penable && !apb_rsp_out.pready |=> apb_rsp_out.pready)
		else $error("APB access not answered after one wait state");

endmodule // raf_unit_filter

// *** raf_host_model.sv ***
// Behavioural RS485 host that frames unit address, broadcast and text characters
`timescale 1ns/1ps
module raf_host_model
(
	input  wire logic               clk_in,
	output raf_pkg::raf_bus_char_s  bus_rx_out
);
	import raf_pkg::*;

	initial bus_rx_out = '0;

	// One character per clock edge
	task automatic put(input logic nine, input logic [8:0] d);
		bus_rx_out <= '{valid: 1'b1, nine: nine, data: d};
		@(posedge clk_in);
	endtask

	// A released line shows inverted stale data, never the last character
	task automatic idle();
		bus_rx_out <= '{valid: 1'b0, nine: 1'b0, data: ~bus_rx_out.data};
		repeat (4) @(posedge clk_in);
	endtask

	// Ninth bit makes the parity even; any character is sent, unit code or not
	task automatic addr(input logic [7:0] c);
		put(1'b1, {^c, c});
		idle();
	endtask

	// Ninth bit makes the parity odd
	task automatic bcast(input logic [7:0] c);
		put(1'b1, {~^c, c});
		idle();
	endtask

	// ASCII text; with parity on, the top bit carries it
	task automatic text(input string s, input logic pen, input logic odd);
		logic [7:0] c;
		foreach (s[i])
		begin
			c = s[i];
			if (pen)
				c[7] = odd ^ (^c[6:0]);
			put(1'b0, {1'b0, c});
		end
		idle();
	endtask
endmodule // raf_host_model

// *** raf_unit_filter_bench.sv ***
// Self-checking bench for the RS485 unit address filter
`timescale 1ns/1ps
module raf_unit_filter_bench;
	import raf_pkg::*;

	localparam int LIMIT = 6000;

	logic          clk_in, nrst_in, ce_in, reply_ready_in;
	raf_apb_req_s  apb_req_in;
	raf_apb_rsp_s  apb_rsp_out;
	raf_char_s     p2p_rx_in, cmd_out;
	raf_bus_char_s bus_rx_in;
	logic          reply_valid_out, cmd_src_bus_out, cmd_end_out, cmd_local_out, bcast_valid_out;
	logic          save_pulse_out, echo_enable_out, panel_lock_out, station_select_enable_out;
	logic          bus_tx_allow_out, multidrop_out, burst_out;
	logic [7:0]    reply_data_out, bcast_code_out;
	logic [3:0]    bcast_combo_out;
	logic [11:0]   cmd_q[$], end_q[$], bc_q[$], rep_q[$];
	logic [31:0]   rd;
	logic          err;
	int            n_errors, n_checks, n_save, cyc;

	raf_unit_filter i_raf_unit_filter
	(
		.clk_in, .nrst_in, .ce_in, .apb_req_in, .apb_rsp_out, .p2p_rx_in, .bus_rx_in,
		.reply_ready_in, .reply_valid_out, .reply_data_out, .cmd_out, .cmd_src_bus_out,
		.cmd_end_out, .cmd_local_out, .bcast_valid_out, .bcast_code_out, .bcast_combo_out,
		.save_pulse_out, .echo_enable_out, .panel_lock_out, .station_select_enable_out,
		.bus_tx_allow_out, .multidrop_out, .burst_out
	);

	raf_host_model i_raf_host_model
	(
		.clk_in     (clk_in),
		.bus_rx_out (bus_rx_in)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// Collects every output event; also cuts a hang short
	always @(posedge clk_in)
	begin
		if (cmd_out.valid === 1'b1)
			cmd_q.push_back({3'b0, cmd_src_bus_out, cmd_out.data});
		if (cmd_end_out === 1'b1)
			end_q.push_back({11'b0, cmd_local_out});
		if (bcast_valid_out === 1'b1)
			bc_q.push_back({bcast_combo_out, bcast_code_out});
		if (reply_valid_out === 1'b1)
			rep_q.push_back({4'b0, reply_data_out});
		if (save_pulse_out === 1'b1)
			n_save++;
		cyc++;
		if (cyc == LIMIT)
		begin
			n_errors++;
			$display("[FAIL] %0t run did not complete", $time);
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic qchk(input logic [11:0] q[$], input logic [11:0] e[$]);
		check(q.size(), e.size());
		foreach (e[i])
			if (i < q.size())
				check(q[i], e[i]);
	endtask

	task automatic clr();
		cmd_q.delete();
		end_q.delete();
		bc_q.delete();
		rep_q.delete();
	endtask

	// APB transfer held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		apb_req_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clk_in);
		apb_req_in.penable <= 1'b1;
		do
			@(posedge clk_in);
		while (apb_rsp_out.pready !== 1'b1);
		rd = apb_rsp_out.prdata;
		err = apb_rsp_out.pslverr;
		apb_req_in <= '0;
		@(posedge clk_in);
	endtask

	task automatic p2p(input string s);
		foreach (s[i])
		begin
			p2p_rx_in <= '{valid: 1'b1, data: s[i]};
			@(posedge clk_in);
		end
		p2p_rx_in <= '{valid: 1'b0, data: ~s[s.len() - 1]};
		repeat (8) @(posedge clk_in);
	endtask

	// Local command whose reply is one character and a carriage return
	task automatic loc(input string s, input logic [7:0] r);
		clr();
		p2p(s);
		qchk(rep_q, '{{4'h0, r}, 12'h00d});
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		nrst_in = 1'b0;
		ce_in = 1'b1;
		reply_ready_in = 1'b1;
		apb_req_in = '0;
		p2p_rx_in = '0;
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		check({multidrop_out, echo_enable_out, panel_lock_out, station_select_enable_out}, 4'b0101);
		apb(1'b0, RAF_ADDR_OFS, 32'h0);
		check(rd[7:0], 8'h30);
		apb(1'b0, RAF_PREFIX_OFS, 32'h0);
		check(rd[15:0], 16'h2624);
		apb(1'b0, 8'h10, 32'h0);
		check({err, rd}, {1'b1, 32'h0});
		$display("test registers done");

		loc("EAA\015", RAF_ACK);
		loc("RA\015", 8'h41);
		loc("EAZ\015", RAF_NAK);
		loc("G2\015", RAF_NAK);
		loc("SE\015", RAF_ACK);
		check(n_save, 1);
		// Frozen clock enable: a whole command goes unseen
		clr();
		ce_in <= 1'b0;
		p2p("G4\015");
		ce_in <= 1'b1;
		check(rep_q.size(), 0);
		check(cmd_q.size(), 0);
		check(multidrop_out, 1'b0);
		// Reply held while the consumer stalls; a second reply is dropped
		reply_ready_in <= 1'b0;
		p2p("RA\015");
		check({reply_valid_out, reply_data_out}, 9'h141);
		p2p("EAZ\015");
		check({reply_valid_out, reply_data_out}, 9'h141);
		reply_ready_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		check(rep_q[rep_q.size() - 1], 12'h00d);
		check(rep_q[rep_q.size() - 2], 12'h041);
		check(reply_valid_out, 1'b0);
		$display("test local done");

		loc("G4\015", RAF_ACK);
		check({multidrop_out, echo_enable_out, panel_lock_out, station_select_enable_out}, 4'b1010);
		clr();
		i_raf_host_model.addr(8'h42);
		i_raf_host_model.text("ST\015", 1'b0, 1'b0);
		i_raf_host_model.addr(8'h61);
		i_raf_host_model.text("ST\015", 1'b0, 1'b0);
		i_raf_host_model.bcast(8'h31);
		i_raf_host_model.bcast(8'h58);
		i_raf_host_model.bcast(8'h41);
		check(cmd_q.size(), 0);
		qchk(bc_q, '{12'h131, 12'hf58, 12'h041});
		check({burst_out, bus_tx_allow_out}, 2'b10);
		i_raf_host_model.addr(8'h41);
		i_raf_host_model.text("ST\015AB\015", 1'b0, 1'b0);
		qchk(cmd_q, '{12'h153, 12'h154, 12'h10d});
		qchk(end_q, '{12'h000});
		check(bus_tx_allow_out, 1'b1);
		loc("RA\015", 8'h41);
		check(multidrop_out, 1'b0);
		$display("test standard done");

		apb(1'b1, RAF_PREFIX_OFS, 32'h2523);
		apb(1'b0, RAF_PREFIX_OFS, 32'h0);
		check(rd[15:0], 16'h2523);
		loc("UA\015", RAF_ACK);
		apb(1'b0, RAF_CTRL_OFS, 32'h0);
		check(rd[0], 1'b1);
		loc("G4\015", RAF_ACK);
		clr();
		i_raf_host_model.text("#BST\015%2#AST\015", 1'b0, 1'b0);
		qchk(cmd_q, '{12'h153, 12'h154, 12'h10d});
		qchk(bc_q, '{12'h232});
		loc("US\015", RAF_ACK);
		apb(1'b0, RAF_CTRL_OFS, 32'h0);
		check(rd[0], 1'b0);
		$display("test prefix done");

		apb(1'b1, RAF_CTRL_OFS, 32'h6);
		loc("G4\015", RAF_ACK);
		check(station_select_enable_out, 1'b1);
		clr();
		i_raf_host_model.addr(8'h41);
		i_raf_host_model.text("ST\015", 1'b1, 1'b0);
		qchk(cmd_q, '{12'h153, 12'h154, 12'h10d});
		i_raf_host_model.addr(8'h41);
		i_raf_host_model.text("S", 1'b1, 1'b1);
		qchk(end_q, '{12'h000, 12'h001});
		$display("test parity done");

		// Reset in mid-run, while in multidrop mode with parity on
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		check({multidrop_out, echo_enable_out, panel_lock_out, station_select_enable_out}, 4'b0101);
		check({burst_out, bus_tx_allow_out}, 2'b01);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		apb(1'b0, RAF_CTRL_OFS, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, RAF_PREFIX_OFS, 32'h0);
		check(rd[15:0], 16'h2624);
		apb(1'b0, RAF_ADDR_OFS, 32'h0);
		check(rd[7:0], 8'h30);
		$display("test reset done");
		finish_test();
	end
endmodule // raf_unit_filter_bench
